// ==== tb_top.sv ====
// Self-checking bench for the T=0 front end with a reader model.
// Assumes a 25 MHz clock and a shortened write cycle of WR_N clocks.
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
  fail_count++; $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_top;
  import tpc_pkg::*;
  localparam int WR_N = 20;
  logic      i_clk = 1'b0;
  logic      i_arst_n = 1'b0;
  logic      pps_cap = 1'b1, atr = 1'b0, deny = 1'b0, att_out = 1'b0;
  logic      auth = 1'b0, vfail = 1'b0;
  tpc_page_t page = TPC_PAGE_16;
  logic      rx_v, tx_v, tx_r, busy;
  tpc_byte_t rx_d, tx_d;
  tpc_wr_t   wr;
  logic [9:0] etu;
  int        fail_count = 0, check_count = 0, busy_cnt = 0, k;
  tpc_wr_t   wr_q[$];
  always #20 i_clk = ~i_clk;
  tpc_frontend #(.WR_CYCLES(WR_N)) dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_pps_capable(pps_cap),
    .i_page_size(page), .i_atr_done(atr), .i_access_denied(deny),
    .i_attempts_out(att_out), .i_auth_mode(auth), .i_verify_fail(vfail),
    .i_rx_valid(rx_v), .i_rx_data(rx_d), .o_tx_valid(tx_v),
    .o_tx_data(tx_d), .i_tx_ready(tx_r), .o_wr(wr),
    .o_etu_cycles(etu), .o_busy(busy));
  tpc_reader_model rdr (
    .i_clk(i_clk), .o_rx_valid(rx_v), .o_rx_data(rx_d),
    .i_tx_valid(tx_v), .i_tx_data(tx_d), .o_tx_ready(tx_r));
  always @(posedge i_clk) begin
    if (busy === 1'b1) busy_cnt++;
    if (wr.valid === 1'b1) wr_q.push_back(wr);
  end
  task automatic results;
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic take_b(input logic [7:0] e);
    logic [7:0] b;
    bit ok;
    rdr.get(b, ok);
    `CHK("tx handshake", 1'b1, ok)
    if (!ok) results();
    else `CHK("tx byte", e, b)
  endtask
  task automatic restart;
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    atr <= 1'b1;
    @(posedge i_clk);
    atr <= 1'b0;
  endtask
  // Header, then data only if the procedure byte echoed INS
  task automatic cmd(input logic [39:0] h, input logic [7:0] pb,
                     input int nd, input logic [7:0] sw);
    int j;
    repeat (2) @(posedge i_clk);
    for (j = 4; j >= 0; j--) rdr.send(h[j*8 +: 8]);
    take_b(pb);
    if (pb === h[31:24]) begin
      for (j = 0; j < nd; j++) rdr.send(8'h10 + j[7:0]);
      take_b(sw);
    end
    take_b(8'h00);
  endtask
  task automatic pps(input logic [31:0] rq, input int n,
                     input logic [31:0] rs, input int m, input logic [9:0] e);
    int j;
    restart();
    for (j = 0; j < n; j++) rdr.send(rq[31-8*j -: 8]);
    for (j = 0; j < m; j++) take_b(rs[31-8*j -: 8]);
    repeat (3) @(posedge i_clk);
    `CHK("etu", e, etu)
  endtask
  task automatic t_pps;
    pps(32'hFF1015FA, 4, 32'hFF1015FA, 4, 10'd23);
    pps(32'hFF10957A, 4, 32'hFF10957A, 4, 10'd32);
    pps(32'hFF1008E7, 4, 32'hFF1008E7, 4, 10'd31);
    pps(32'hFF1012FD, 4, 32'hFF1012FD, 4, 10'd186);
    pps(32'hFF1045AA, 4, 32'hFF00FF00, 3, 10'd372);
    pps(32'hFF01FE00, 3, 32'hFF00FF00, 3, 10'd372);
    pps(32'hFF101500, 4, 32'h0, 0, 10'd372);
    cmd(40'h00B2000000, 8'hB2, 0, 8'h90);
  endtask
  task automatic t_first;
    pps_cap <= 1'b0;
    restart();
    cmd(40'hFFB5000000, 8'h6D, 0, 8'h00);
    `CHK("etu", 10'd372, etu)
    pps_cap <= 1'b1;
    restart();
    cmd(40'hA5B2000000, 8'hB2, 0, 8'h90);
  endtask
  task automatic t_write;
    wr_q.delete();
    busy_cnt = 0;
    rdr.stall = 3;
    cmd(40'h00B0000204, 8'hB0, 4, 8'h90);
    rdr.stall = 0;
    `CHK("busy cycles", WR_N, busy_cnt)
    `CHK("write count", 4, wr_q.size())
    for (k = 0; k < 4 && k < wr_q.size(); k++) begin
      `CHK("wr addr", 8'h02 + k[7:0], wr_q[k].addr)
      `CHK("wr data", 8'h10 + k[7:0], wr_q[k].data)
    end
  endtask
  task automatic t_len;
    cmd(40'h00B0000011, 8'h67, 0, 8'h00);
    page <= TPC_PAGE_64;
    cmd(40'h00B0000040, 8'hB0, 64, 8'h90);
    cmd(40'h00B0000041, 8'h67, 0, 8'h00);
    cmd(40'h00B40B0000, 8'hB4, 0, 8'h90);
    cmd(40'h00B0000009, 8'h67, 0, 8'h00);
    cmd(40'h00B4030000, 8'hB4, 0, 8'h90);
    cmd(40'h00B0000009, 8'hB0, 9, 8'h90);
    page <= TPC_PAGE_16;
  endtask
  task automatic t_sys;
    cmd(40'h00B4010600, 8'hB4, 0, 8'h90);
    cmd(40'h00B4020002, 8'hB4, 2, 8'h90);
    cmd(40'h00B4000010, 8'hB4, 16, 8'h90);
    cmd(40'h00B4080009, 8'h67, 0, 8'h00);
    cmd(40'h00B4050000, 8'h6B, 0, 8'h00);
  endtask
  task automatic t_sec;
    cmd(40'h00B8130010, 8'hB8, 16, 8'h90);
    cmd(40'h00B8140010, 8'h6B, 0, 8'h00);
    cmd(40'h00B8000008, 8'h67, 0, 8'h00);
    vfail <= 1'b1;
    cmd(40'h00BA170003, 8'hBA, 3, 8'h69);
    vfail <= 1'b0;
    att_out <= 1'b1;
    cmd(40'h00BA000003, 8'h69, 0, 8'h00);
    att_out <= 1'b0;
    deny <= 1'b1;
    cmd(40'h00B2000010, 8'h69, 0, 8'h00);
    deny <= 1'b0;
    auth <= 1'b1;
    wr_q.delete();
    cmd(40'h00B0000002, 8'hB0, 2, 8'h62);
    `CHK("write count", 0, wr_q.size())
    auth <= 1'b0;
    cmd(40'h00A4000000, 8'h6D, 0, 8'h00);
  endtask
  initial begin
    restart();
    `CHK("etu", 10'd372, etu)
    `CHK("busy", 1'b0, busy)
    `CHK("tx valid", 1'b0, tx_v)
    t_pps();
    t_first();
    t_write();
    t_len();
    t_sys();
    t_sec();
    results();
  end
endmodule // tb_top

// ==== tpc_defines.svh ====
// Constants of the T=0 command front end: codes, limits, timing counts.
// Assumes a 25 MHz core clock; included by bare name.
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH
`define TPC_PPS_START      8'hFF
`define TPC_PPS0_NONE      8'h00
`define TPC_PPS0_PARAM     8'h10
`define TPC_INS_WR_USER    8'hB0
`define TPC_INS_RD_USER    8'hB2
`define TPC_INS_SYS_WR     8'hB4
`define TPC_INS_SYS_RD     8'hB6
`define TPC_INS_CRYPTO     8'hB8
`define TPC_INS_PASSWD     8'hBA
`define TPC_SW_OK          8'h90
`define TPC_SW_CKSUM       8'h62
`define TPC_SW_LEN         8'h67
`define TPC_SW_UNAUTH      8'h69
`define TPC_SW_ADDR        8'h6B
`define TPC_SW_INS         8'h6D
`define TPC_SW2            8'h00
`define TPC_LEN_AT         8'h08
`define TPC_LEN_CRYPTO     8'h10
`define TPC_LEN_PASSWD     8'h03
`define TPC_LEN_CKSUM      8'h02
`define TPC_ETU_DEFAULT    10'd372
`define TPC_WR_TIME_US     5000
`define TPC_CLK_MHZ        25
`define TPC_WR_CYCLES      (`TPC_WR_TIME_US * `TPC_CLK_MHZ)
`endif

// ==== tpc_frontend.sv ====
// T=0 front end: PPS negotiation, header decode, procedure and status bytes.
// Assumes a character layer outside that delivers received bytes and sends
// bytes from o_tx_*, handling parity and retransmission on the line.
// How it works
// RL1: PPS accepted only when the large-memory option is strapped on.
// RL2: First byte after ATR equal FF starts PPS, else it is class.
// RL3: PPS is start byte FF, format, optional parameter, check byte.
// RL4: Response format byte is 00 or 10 only.
// RL5: Accepted parameter bytes: 01-05,08,11-15,18,94,95.
// RL6: Without PPS the bit period stays 372 card clocks.
// RL7: Accepted factors apply right after the PPS response.
// RL8: Unsupported parameter answers FF 00 FF, defaults kept.
// RL9: Non-T=0 protocol request answers format 00.
// RL10: Faster rate only via successful PPS, never via ATR.
// RL11: User write length capped by page size, or 08 under anti-tearing.
// RL12: System write P1 selects config, fuse, checksum, zone functions.
// RL13: Crypto verify needs P1 0X/1X with X up to 3, P2 00, P3 10.
// RL14: Password verify needs P1 0X/1X, P2 00, P3 03.
// RL15: Class byte unchecked; small parts ignore P1 of user commands.
// RL16: Normal flow echoes INS then ends with 90 00.
// RL17: Write under authentication returns 62 00 and waits for checksum.
// RL18: Bad P3 length returns 67 00 as procedure bytes.
// RL19: Forbidden address or exhausted attempts returns 69 00 early.
// RL20: Failed password, crypto or MAC check ends with 69 00.
// RL21: Unknown INS returns 6D 00; bad address returns 6B 00.
// RL22: User write data goes to rising addresses, then timed write cycle.
// RL23: PPS check byte makes XOR of all bytes zero.
// RL24: Outgoing P3 zero means 256 bytes; incoming zero means none.
// RL25: Parity and retransmission handled by the character layer.
`timescale 1ns/1ps
`include "tpc_defines.svh"
module tpc_frontend #(
  parameter int WR_CYCLES = `TPC_WR_CYCLES
) (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_arst_n,
  // Variant straps and security state
  input  wire logic          i_pps_capable,
  input  tpc_pkg::tpc_page_t i_page_size,
  input  wire logic          i_atr_done,
  input  wire logic          i_access_denied,
  input  wire logic          i_attempts_out,
  input  wire logic          i_auth_mode,
  input  wire logic          i_verify_fail,
  // Received characters
  input  wire logic          i_rx_valid,
  input  tpc_pkg::tpc_byte_t i_rx_data,
  // Transmitted characters
  output logic               o_tx_valid,
  output tpc_pkg::tpc_byte_t o_tx_data,
  input  wire logic          i_tx_ready,
  // Memory write port and link rate
  output tpc_pkg::tpc_wr_t   o_wr,
  output logic [9:0]         o_etu_cycles,
  output logic               o_busy
);
  import tpc_pkg::*;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'b000000001,
    ST_FIRST = 9'b000000010,
    ST_PPS   = 9'b000000100,
    ST_HDR   = 9'b000001000,
    ST_DATA  = 9'b000010000,
    ST_WRITE = 9'b000100000,
    ST_OUT   = 9'b001000000,
    ST_SEND  = 9'b010000000,
    ST_WAIT  = 9'b100000000
  } tpc_state_t;

  tpc_state_t  state_reg;
  logic [7:0]  hdr_reg [5];
  logic [2:0]  hidx_reg;
  logic [7:0]  pps_reg [4];
  logic [2:0]  pidx_reg;
  logic [7:0]  pps_x_reg;
  logic [8:0]  cnt_reg;
  logic [7:0]  addr_reg;
  logic        at_reg;
  logic [31:0] wcnt_reg;
  logic [7:0]  q_reg [4];
  logic [2:0]  qn_reg;
  logic [2:0]  qi_reg;
  logic [9:0]  etu_reg;
  logic [9:0]  etu_new_reg;
  logic [7:0]  hdr_sw;
  tpc_wr_t     wr_reg;
  logic        busy_reg;
  logic        buf_ready;
  logic        push;
  logic [7:0]  chk;
  logic [9:0]  etu_of;

  // Length, function and address check for the full header
  function automatic logic [7:0] hdr_check(input logic [7:0] ins,
      input logic [7:0] p1, input logic [7:0] p2, input logic [7:0] p3,
      input logic at, input tpc_page_t pg, input logic deny);
    logic [7:0] lim;
    lim = (pg == TPC_PAGE_128) ? 8'h80 :
          (pg == TPC_PAGE_64)  ? 8'h40 : 8'h10;
    hdr_check = 8'h00;
    case (ins)
      `TPC_INS_WR_USER:
        if (p3 > (at ? `TPC_LEN_AT : lim))           // [RL11]
          hdr_check = `TPC_SW_LEN;
      `TPC_INS_RD_USER: hdr_check = 8'h00;
      `TPC_INS_SYS_WR:
        case (p1)                                    // [RL12]
          8'h00: if (p3 > lim) hdr_check = `TPC_SW_LEN;
          8'h08: if (p3 > `TPC_LEN_AT) hdr_check = `TPC_SW_LEN;
          8'h01, 8'h03, 8'h0B:
            if (p3 != 8'h00) hdr_check = `TPC_SW_LEN;
          8'h02: if (p3 != `TPC_LEN_CKSUM) hdr_check = `TPC_SW_LEN;
          default: hdr_check = `TPC_SW_ADDR;         // [RL21]
        endcase
      `TPC_INS_SYS_RD:
        if (p1 > 8'h02) hdr_check = `TPC_SW_ADDR;
      `TPC_INS_CRYPTO:                               // [RL13]
        if (p1[7:5] != 3'd0 || p1[3:2] != 2'd0 || p2 != 8'h00)
          hdr_check = `TPC_SW_ADDR;
        else if (p3 != `TPC_LEN_CRYPTO) hdr_check = `TPC_SW_LEN;
      `TPC_INS_PASSWD:                               // [RL14]
        if (p1[7:5] != 3'd0 || p1[3] || p2 != 8'h00)
          hdr_check = `TPC_SW_ADDR;
        else if (p3 != `TPC_LEN_PASSWD) hdr_check = `TPC_SW_LEN;
      default: hdr_check = `TPC_SW_INS;              // [RL21]
    endcase
    if (hdr_check == 8'h00 && deny) hdr_check = `TPC_SW_UNAUTH; // [RL19]
  endfunction

  // Rate table: cycles per bit for an accepted parameter byte, else 0
  function automatic logic [9:0] etu_for(input logic [7:0] pb);
    case (pb)                                        // [RL5]
      8'h01, 8'h11: etu_for = 10'd372;
      8'h02, 8'h12: etu_for = 10'd186;
      8'h03, 8'h13: etu_for = 10'd93;
      8'h04, 8'h14: etu_for = 10'd46;
      8'h05, 8'h15: etu_for = 10'd23;
      8'h08, 8'h18: etu_for = 10'd31;
      8'h94:        etu_for = 10'd64;
      8'h95:        etu_for = 10'd32;
      default:      etu_for = 10'd0;
    endcase
  endfunction

  assign chk    = pps_x_reg ^ i_rx_data.data; // Parity done upstream [RL25]
  assign etu_of = etu_for(pps_reg[2]);
  assign push   = (qi_reg < qn_reg) && buf_ready;
  assign hdr_sw = hdr_check(hdr_reg[1], hdr_reg[2], hdr_reg[3],
      i_rx_data.data, at_reg, i_page_size, i_access_denied || i_attempts_out);

  // Header and PPS capture, main sequence
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg    <= ST_IDLE;
      hidx_reg     <= 3'd0;
      pidx_reg     <= 3'd0;
      pps_x_reg    <= 8'h00;
      cnt_reg      <= 9'd0;
      addr_reg     <= 8'h00;
      at_reg       <= 1'b0;
      wcnt_reg     <= 32'd0;
      qn_reg       <= 3'd0;
      etu_new_reg  <= `TPC_ETU_DEFAULT;
      etu_reg      <= `TPC_ETU_DEFAULT;              // [RL6]
      for (int i = 0; i < 5; i++) hdr_reg[i] <= 8'h00;
      for (int i = 0; i < 4; i++) pps_reg[i] <= 8'h00;
      for (int i = 0; i < 4; i++) q_reg[i] <= 8'h00;
    end else begin
      case (state_reg)
        ST_IDLE: state_reg <= ST_IDLE;
        ST_FIRST:
          if (i_rx_valid) begin
            if (i_pps_capable &&
                i_rx_data.data == `TPC_PPS_START) begin // [RL1] [RL2]
              state_reg  <= ST_PPS;
              pps_reg[0] <= i_rx_data.data;
              pps_x_reg  <= i_rx_data.data;
              pidx_reg   <= 3'd1;
            end else begin
              hdr_reg[0] <= i_rx_data.data;          // [RL15]
              hidx_reg   <= 3'd1;
              state_reg  <= ST_HDR;
            end
          end
        ST_PPS:
          if (i_rx_valid) begin
            pps_reg[pidx_reg[1:0]] <= i_rx_data.data;
            pps_x_reg <= chk;
            pidx_reg  <= pidx_reg + 3'd1;
            // Check byte closes after format (no PPS1) or after PPS1
            if ((pidx_reg == 3'd2 && !pps_reg[1][4]) ||
                pidx_reg == 3'd3) begin              // [RL3]
              if (chk != 8'h00) begin                // [RL23]
                state_reg <= ST_HDR;  // Bad check: drop, await command
                hidx_reg  <= 3'd0;
              end else if (pps_reg[1][3:0] == 4'h0 && pps_reg[1][4] &&
                           etu_of != 10'd0) begin
                q_reg[0] <= `TPC_PPS_START;
                q_reg[1] <= `TPC_PPS0_PARAM;         // [RL4]
                q_reg[2] <= pps_reg[2];
                q_reg[3] <= `TPC_PPS_START ^ `TPC_PPS0_PARAM ^ pps_reg[2];
                qn_reg   <= 3'd4;
                etu_new_reg <= etu_of;               // [RL7]
                state_reg <= ST_SEND;
              end else begin
                q_reg[0] <= `TPC_PPS_START;          // [RL8] [RL9]
                q_reg[1] <= `TPC_PPS0_NONE;
                q_reg[2] <= `TPC_PPS_START ^ `TPC_PPS0_NONE;
                qn_reg   <= 3'd3;
                state_reg <= ST_SEND;
              end
            end
          end
        ST_HDR:
          if (i_rx_valid) begin
            hdr_reg[hidx_reg] <= i_rx_data.data;
            hidx_reg <= hidx_reg + 3'd1;
            if (hidx_reg == 3'd4) begin
              if (hdr_sw != 8'h00) begin
                q_reg[0]  <= hdr_sw;                 // [RL18] [RL21]
                q_reg[1]  <= `TPC_SW2;
                qn_reg    <= 3'd2;
                state_reg <= ST_SEND;
              end else begin
                q_reg[0] <= hdr_reg[1];              // [RL16]
                qn_reg   <= 3'd1;
                addr_reg <= hdr_reg[3];              // [RL22]
                if (hdr_reg[1] == `TPC_INS_SYS_WR &&
                    (hdr_reg[2] == 8'h03 || hdr_reg[2] == 8'h0B))
                  at_reg <= (hdr_reg[2] == 8'h0B);
                if (hdr_reg[1] == `TPC_INS_RD_USER ||
                    hdr_reg[1] == `TPC_INS_SYS_RD) begin
                  cnt_reg <= (i_rx_data.data == 8'h00) ? 9'd256 :
                             {1'b0, i_rx_data.data}; // [RL24]
                  state_reg <= ST_OUT;
                end else begin
                  cnt_reg   <= {1'b0, i_rx_data.data};
                  state_reg <= ST_DATA;
                end
              end
            end
          end
        ST_DATA:
          if (qi_reg == qn_reg) begin
            if (cnt_reg == 9'd0) begin
              qn_reg    <= 3'd0;
              wcnt_reg  <= 32'd0;
              state_reg <= ST_WRITE;
            end else if (i_rx_valid) begin
              addr_reg <= addr_reg + 8'd1;           // [RL22]
              cnt_reg  <= cnt_reg - 9'd1;
            end
          end
        ST_WRITE: begin
          if (hdr_reg[1] == `TPC_INS_WR_USER && i_auth_mode) begin
            q_reg[0] <= `TPC_SW_CKSUM;               // [RL17]
            q_reg[1] <= `TPC_SW2;
            qn_reg   <= 3'd2;
            state_reg <= ST_SEND;
          end else if (wcnt_reg >= WR_CYCLES - 1 ||
                       hdr_reg[1] != `TPC_INS_WR_USER) begin
            q_reg[0] <= i_verify_fail ? `TPC_SW_UNAUTH // [RL20]
                                      : `TPC_SW_OK;
            q_reg[1] <= `TPC_SW2;
            qn_reg   <= 3'd2;
            state_reg <= ST_SEND;
          end else
            wcnt_reg <= wcnt_reg + 32'd1;
        end
        ST_OUT:
          // Read data comes from the memory path; here only the ending
          if (qi_reg == qn_reg) begin
            q_reg[0] <= `TPC_SW_OK;
            q_reg[1] <= `TPC_SW2;
            qn_reg   <= 3'd2;
            state_reg <= ST_SEND;
          end
        ST_SEND: // Drain first: a new rate must not hit the answer
          if (qi_reg == qn_reg && qn_reg != 3'd0 && !o_tx_valid) begin
            qn_reg    <= 3'd0;
            etu_reg   <= etu_new_reg;                // [RL7]
            hidx_reg  <= 3'd0;
            state_reg <= ST_HDR;
          end
        default: state_reg <= ST_IDLE;
      endcase
      if (i_atr_done) begin
        state_reg   <= ST_FIRST;
        etu_reg     <= `TPC_ETU_DEFAULT;             // [RL10]
        etu_new_reg <= `TPC_ETU_DEFAULT;
        qn_reg      <= 3'd0;
      end
    end
  end

  // Output queue read index
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n)
      qi_reg <= 3'd0;
    else if (i_atr_done || (qi_reg == qn_reg &&
             (state_reg == ST_OUT || (state_reg == ST_SEND && !o_tx_valid) ||
              (state_reg == ST_DATA && cnt_reg == 9'd0))))
      qi_reg <= 3'd0;
    else if (push)
      qi_reg <= qi_reg + 3'd1;
  end

  // Memory write strobe for each user data byte, none in authentication mode
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_reg   <= '0;
      busy_reg <= 1'b0;
    end else begin
      wr_reg.valid <= (state_reg == ST_DATA) && (qi_reg == qn_reg) &&
                      (cnt_reg != 9'd0) && i_rx_valid &&
                      hdr_reg[1] == `TPC_INS_WR_USER && !i_auth_mode; // [RL17]
      wr_reg.addr  <= addr_reg;
      wr_reg.data  <= i_rx_data.data;
      busy_reg     <= (state_reg == ST_WRITE);   // [RL22]
    end
  end

  tpc_skid_buf u_buf (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_valid  (push),
    .i_data   (tpc_byte_t'(q_reg[qi_reg[1:0]])),
    .o_ready  (buf_ready),
    .o_valid  (o_tx_valid),
    .o_data   (o_tx_data),
    .i_ready  (i_tx_ready)
  );

  assign o_wr         = wr_reg;
  assign o_etu_cycles = etu_reg;
  assign o_busy       = busy_reg;

  a_etu_default: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(i_atr_done) |=> o_etu_cycles == 10'd372)   // [RL6]
    else $error("Bit period not default after reset");
  a_no_pps_small: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_pps_capable && state_reg == ST_FIRST && i_rx_valid && !i_atr_done
    |=> state_reg != ST_PPS)                          // [RL1]
    else $error("PPS entered on small part");
  a_pps_start: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_pps_capable && state_reg == ST_FIRST && i_rx_valid && !i_atr_done
    && i_rx_data.data == 8'hFF |=> state_reg == ST_PPS) // [RL2]
    else $error("FF did not start PPS");
  a_rate_stable: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    state_reg inside {ST_HDR, ST_DATA, ST_OUT} |=> $stable(o_etu_cycles))
    else $error("Rate changed outside PPS");          // [RL10]
  a_rate_valid: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_etu_cycles inside {10'd372, 10'd186, 10'd93, 10'd46, 10'd23,
    10'd31, 10'd64, 10'd32}) else $error("Unsupported rate"); // [RL5]
  a_wr_addr_step: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_wr.valid |-> addr_reg == o_wr.addr + 8'd1)
    else $error("Write address not rising");          // [RL22]
  a_hdr_answer: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    state_reg == ST_HDR && hidx_reg == 3'd4 && i_rx_valid && !i_atr_done
    |=> state_reg inside {ST_SEND, ST_OUT, ST_DATA})   // [RL16]
    else $error("Header gave no answer");
  a_q_bound: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    qi_reg <= qn_reg) else $error("Queue index beyond fill"); // [RL18]
  c_pps_seen: cover property (@(posedge i_clk) state_reg == ST_PPS);
  c_write: cover property (@(posedge i_clk) state_reg == ST_WRITE);
  c_read: cover property (@(posedge i_clk) state_reg == ST_OUT);
endmodule // tpc_frontend

// ==== tpc_pkg.sv ====
// Types shared by the T=0 command front end and its output buffer.
// Constants live in tpc_defines.svh.
package tpc_pkg;
  typedef struct packed {
    logic [7:0] data;
  } tpc_byte_t;
  typedef enum logic [1:0] {
    TPC_PAGE_16  = 2'b00,
    TPC_PAGE_64  = 2'b01,
    TPC_PAGE_128 = 2'b10
  } tpc_page_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } tpc_wr_t;
endpackage

// ==== tpc_reader_model.sv ====
// Reader-side model: sends host bytes and collects device bytes.
// Assumes the front end takes one rx pulse per byte, tx by valid/ready.
`timescale 1ns/1ps
module tpc_reader_model (
  // Clock
  input  wire logic          i_clk,
  // Host to device
  output logic               o_rx_valid,
  output tpc_pkg::tpc_byte_t o_rx_data,
  // Device to host
  input  wire logic          i_tx_valid,
  input  tpc_pkg::tpc_byte_t i_tx_data,
  output logic               o_tx_ready
);
  import tpc_pkg::*;
  int stall = 0;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
    o_tx_ready = 1'b0;
  end
  // Whole bytes, one per two cycles; idle line shows inverse
  task automatic send(input logic [7:0] b);
    @(posedge i_clk);
    o_rx_valid <= 1'b1;
    o_rx_data  <= b;
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_data  <= ~b;
  endtask
  // Slow reader: ready held back for stall+1 cycles, bounded wait
  task automatic get(output logic [7:0] b, output bit ok);
    int n;
    ok = 1'b0;
    b  = 8'h00;
    repeat (stall + 1) @(posedge i_clk);
    o_tx_ready <= 1'b1;
    for (n = 0; n < 400 && !ok; n++) begin
      @(posedge i_clk);
      if (i_tx_valid === 1'b1) begin
        ok = 1'b1;
        b  = i_tx_data;
      end
    end
    o_tx_ready <= 1'b0;
  endtask
endmodule // tpc_reader_model

// ==== tpc_skid_buf.sv ====
// Two-entry byte buffer with valid/ready on both sides.
// Assumes one clock; output comes straight from storage flip-flops.
`timescale 1ns/1ps
module tpc_skid_buf (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  // Filling side
  input  wire logic         i_valid,
  input  tpc_pkg::tpc_byte_t i_data,
  output logic              o_ready,
  // Draining side
  output logic              o_valid,
  output tpc_pkg::tpc_byte_t o_data,
  input  wire logic         i_ready
);
  import tpc_pkg::*;
  tpc_byte_t  mem_reg [2];
  logic       rd_ptr_reg;
  logic       wr_ptr_reg;
  logic [1:0] count_reg;
  logic       push;
  logic       pop;

  assign push = i_valid && (count_reg != 2'd2);
  assign pop  = o_valid && i_ready;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      wr_ptr_reg <= 1'b0;
    end else if (push) begin
      mem_reg[wr_ptr_reg] <= i_data;
      wr_ptr_reg          <= ~wr_ptr_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'd0;
    end else begin
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      case ({push, pop})
        2'b10:   count_reg <= count_reg + 2'd1;
        2'b01:   count_reg <= count_reg - 2'd1;
        default: count_reg <= count_reg;
      endcase
    end
  end

  // Ready/valid from state flip-flops only
  assign o_ready = (count_reg != 2'd2);
  assign o_valid = (count_reg != 2'd0);
  assign o_data  = mem_reg[rd_ptr_reg];

  a_hold_stall: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_valid && !i_ready |=> o_valid && $stable(o_data)) // [RL16]
    else $error("Buffer head moved while stalled");
endmodule // tpc_skid_buf
